/* design/tco_pkg.sv */
// tco_pkg: constants, modes and state types shared by the timer compare-output block.
// assumes one 100 MHz clock; the timer clock is a one-cycle enable made by the prescaler.
package tco_pkg;

  localparam int CNT_W = 8;
  localparam int CH_N = 2;
  localparam int CH_A = 0;
  localparam int CH_B = 1;

  localparam logic [CNT_W-1:0] CNT_BOTTOM = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;

  // waveform generation modes handled here; odd codes are the PWM modes
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam int WGM_PWM_BIT = 0;

  // compare output mode actions in the non-PWM modes
  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  localparam logic OC_RESET = 1'b0;
  localparam logic FLAG_RESET = 1'b0;

  // clock select codes and prescale factors N
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam int PRE_W = 10;
  localparam logic [PRE_W-1:0] PRE_RESET = 10'h000;
  localparam logic [PRE_W-1:0] PRE_ONE = 10'h001;
  localparam logic [PRE_W-1:0] PRE_MASK8 = 10'h007;
  localparam logic [PRE_W-1:0] PRE_MASK64 = 10'h03F;
  localparam logic [PRE_W-1:0] PRE_MASK256 = 10'h0FF;
  localparam logic [PRE_W-1:0] PRE_MASK1024 = 10'h3FF;

  typedef struct packed {
    logic [PRE_W-1:0] div;
    logic tick;
  } tco_pre_state_t;

  typedef struct packed {
    logic oc;
  } tco_ch_state_t;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic blockNext;
    logic [CH_N-1:0] matchFlag;
    logic overflowFlag;
    logic [CH_N-1:0] pinOut;
    logic [CH_N-1:0] pinOe_n;
  } tco_top_state_t;

endpackage : tco_pkg

/* design/tco_ch_if.sv */
// tco_ch_if: signals between the timer core and one compare channel.
// assumes the core drives the timer side and the channel drives match and output state.
`timescale 1ns/10ps
interface tco_ch_if;
  import tco_pkg::*;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] compareValue;
  logic [1:0] compareOutputMode;
  logic tick;
  logic blocked;
  logic nonPwm;
  logic forceCompareStrobe;
  logic matchHit;
  logic compareOutput;

  modport core (
    output count, compareValue, compareOutputMode, tick, blocked, nonPwm, forceCompareStrobe,
    input matchHit, compareOutput
  );
  modport unit (
    input count, compareValue, compareOutputMode, tick, blocked, nonPwm, forceCompareStrobe,
    output matchHit, compareOutput
  );
endinterface : tco_ch_if

/* design/tco_prescaler.sv */
// tco_prescaler: free-running divider making the one-cycle timer clock enable.
// assumes a synchronous active-low reset from the top's synchroniser.
`timescale 1ns/10ps
module tco_prescaler
  import tco_pkg::*;
(
  input wire logic clk,
  input wire logic rstSync_n,
  input wire logic [2:0] clockSelect,
  output logic timerTick
);

  tco_pre_state_t st_r;
  tco_pre_state_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.div = st_r.div + PRE_ONE;
    // selectable factors N = 1, 8, 64, 256, 1024; other codes stop the timer
    case (clockSelect)
      CS_DIV1: st_nxt.tick = 1'b1;
      CS_DIV8: st_nxt.tick = ((st_r.div & PRE_MASK8) == PRE_MASK8);
      CS_DIV64: st_nxt.tick = ((st_r.div & PRE_MASK64) == PRE_MASK64);
      CS_DIV256: st_nxt.tick = ((st_r.div & PRE_MASK256) == PRE_MASK256);
      CS_DIV1024: st_nxt.tick = ((st_r.div & PRE_MASK1024) == PRE_MASK1024);
      default: st_nxt.tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstSync_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign timerTick = st_r.tick;

endmodule : tco_prescaler

/* design/tco_compare_unit.sv */
// tco_compare_unit: one compare channel, its comparator and its compare output register.
// assumes the core supplies count, timer tick, match blocking and the mode bits.
`timescale 1ns/10ps
module tco_compare_unit
  import tco_pkg::*;
(
  input wire logic clk,
  input wire logic rstSync_n,
  tco_ch_if.unit ch
);

  tco_ch_state_t st_r;
  tco_ch_state_t st_nxt;
  logic equal;
  logic act;

  assign equal = (ch.count == ch.compareValue);
  // a match counts only on a timer tick that is not blocked by a count write
  assign ch.matchHit = ch.tick & ~ch.blocked & equal;

  // force only in non-PWM modes; it shares the action path but never reaches the flag
  assign act = (ch.matchHit & ch.nonPwm) | (ch.forceCompareStrobe & ch.nonPwm);

  always_comb
  begin
    st_nxt = st_r;
    // mode bits are read live, so a new setting applies to the next match or force
    if (act)
    begin
      case (ch.compareOutputMode)
        COM_TOGGLE: st_nxt.oc = ~st_r.oc;
        COM_CLEAR: st_nxt.oc = 1'b0;
        COM_SET: st_nxt.oc = 1'b1;
        default: st_nxt.oc = st_r.oc;
      endcase
    end
  end

  // no dependence on waveform mode changes: the register just holds
  always_ff @(posedge clk)
  begin
    if (!rstSync_n)
    begin
      st_r.oc <= OC_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign ch.compareOutput = st_r.oc;

endmodule : tco_compare_unit

/* design/tco_timer_top.sv */
// tco_timer_top: 8-bit timer core in normal and clear-on-match modes with two compare outputs.
// assumes control inputs are synchronous to clk; strobes are one-cycle pulses from the cpu side.
`timescale 1ns/10ps
module tco_timer_top
  import tco_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] clockSelect,
  input wire logic [2:0] waveformGenMode,
  input wire logic [1:0] compareOutputModeA,
  input wire logic [1:0] compareOutputModeB,
  input wire logic [CNT_W-1:0] compareValueA,
  input wire logic [CNT_W-1:0] compareValueB,
  input wire logic countWriteStrobe,
  input wire logic [CNT_W-1:0] countWriteData,
  input wire logic forceCompareStrobeA,
  input wire logic forceCompareStrobeB,
  input wire logic flagWriteOneA,
  input wire logic flagWriteOneB,
  input wire logic flagWriteOneOverflow,
  input wire logic intServicedA,
  input wire logic intServicedB,
  input wire logic intServicedOverflow,
  input wire logic [CH_N-1:0] portData,
  input wire logic [CH_N-1:0] portDirOut,
  output logic [CNT_W-1:0] timerCount,
  output logic compareMatchFlagA,
  output logic compareMatchFlagB,
  output logic overflowFlag,
  output logic compareOutputA,
  output logic compareOutputB,
  output logic [CH_N-1:0] pinOut,
  output logic [CH_N-1:0] pinOe_n
);

  // reset is released through two flops; only the synchronised copy is used below
  logic rstMeta_r;
  logic rstSync_r;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  logic timerTick;

  tco_prescaler u_prescaler (
    .clk(clk),
    .rstSync_n(rstSync_r),
    .clockSelect(clockSelect),
    .timerTick(timerTick)
  );

  tco_top_state_t st_r;
  tco_top_state_t st_nxt;

  logic modeCtc;
  logic modeNonPwm;
  logic [CH_N-1:0][CNT_W-1:0] cmpVal;
  logic [CH_N-1:0][1:0] comMode;
  logic [CH_N-1:0] forceStb;
  logic [CH_N-1:0] flagClr;
  logic [CH_N-1:0] matchHit;
  logic [CH_N-1:0] ocState;

  // only the waveform mode steers counting; output mode bits never reach this path
  assign modeCtc = (waveformGenMode == WGM_CTC);
  assign modeNonPwm = ~waveformGenMode[WGM_PWM_BIT];

  assign cmpVal[CH_A] = compareValueA;
  assign cmpVal[CH_B] = compareValueB;
  assign comMode[CH_A] = compareOutputModeA;
  assign comMode[CH_B] = compareOutputModeB;
  assign forceStb[CH_A] = forceCompareStrobeA;
  assign forceStb[CH_B] = forceCompareStrobeB;
  assign flagClr[CH_A] = flagWriteOneA | intServicedA;
  assign flagClr[CH_B] = flagWriteOneB | intServicedB;

  tco_ch_if chIf[CH_N] ();

  genvar gi;
  generate
    for (gi = 0; gi < CH_N; gi++)
    begin : g_ch
      assign chIf[gi].count = st_r.count;
      // compare values go straight to the comparator, no buffer in these modes
      assign chIf[gi].compareValue = cmpVal[gi];
      assign chIf[gi].compareOutputMode = comMode[gi];
      assign chIf[gi].tick = timerTick;
      assign chIf[gi].blocked = st_r.blockNext;
      assign chIf[gi].nonPwm = modeNonPwm;
      assign chIf[gi].forceCompareStrobe = forceStb[gi];
      assign matchHit[gi] = chIf[gi].matchHit;
      assign ocState[gi] = chIf[gi].compareOutput;

      tco_compare_unit u_unit (
        .clk(clk),
        .rstSync_n(rstSync_r),
        .ch(chIf[gi].unit)
      );
    end
  endgenerate

  logic ctcClear;
  logic wrapToBottom;

  // only channel A defines the ceiling; channel B never clears the count
  assign ctcClear = modeCtc & matchHit[CH_A];
  // a value of A below the count is simply passed: the counter wraps through MAX first
  assign wrapToBottom = timerTick & ~countWriteStrobe & (st_r.count == CNT_MAX);

  always_comb
  begin
    st_nxt = st_r;

    // counter: cpu write beats every clear and count
    if (countWriteStrobe)
    begin
      st_nxt.count = countWriteData;
    end
    else if (timerTick)
    begin
      if (ctcClear)
      begin
        st_nxt.count = CNT_BOTTOM;
      end
      else
      begin
        st_nxt.count = st_r.count + CNT_ONE;
      end
    end

    // block window: armed by a write, held while the timer is stopped, used up by one tick
    if (countWriteStrobe)
    begin
      st_nxt.blockNext = 1'b1;
    end
    else if (timerTick)
    begin
      st_nxt.blockNext = 1'b0;
    end

    // match flags: set on the tick of a real match; a set beats a clear
    for (int i = 0; i < CH_N; i++)
    begin
      if (matchHit[i])
      begin
        st_nxt.matchFlag[i] = 1'b1;
      end
      else if (flagClr[i])
      begin
        st_nxt.matchFlag[i] = 1'b0;
      end
    end

    // overflow: same tick the count becomes zero, whether wrapped or cleared at 0xFF
    if (wrapToBottom)
    begin
      st_nxt.overflowFlag = 1'b1;
    end
    else if (flagWriteOneOverflow | intServicedOverflow)
    begin
      st_nxt.overflowFlag = 1'b0;
    end

    // pin override: any nonzero mode takes the pin; direction always from the port
    for (int i = 0; i < CH_N; i++)
    begin
      if (comMode[i] != COM_NONE)
      begin
        st_nxt.pinOut[i] = ocState[i];
      end
      else
      begin
        st_nxt.pinOut[i] = portData[i];
      end
      st_nxt.pinOe_n[i] = ~portDirOut[i];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstSync_r)
    begin
      st_r.count <= CNT_RESET;
      st_r.blockNext <= 1'b0;
      st_r.matchFlag <= {CH_N{FLAG_RESET}};
      st_r.overflowFlag <= FLAG_RESET;
      st_r.pinOut <= '0;
      // pins start released so nothing is driven before software sets them up
      st_r.pinOe_n <= '1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign timerCount = st_r.count;
  assign compareMatchFlagA = st_r.matchFlag[CH_A];
  assign compareMatchFlagB = st_r.matchFlag[CH_B];
  assign overflowFlag = st_r.overflowFlag;
  assign compareOutputA = ocState[CH_A];
  assign compareOutputB = ocState[CH_B];
  assign pinOut = st_r.pinOut;
  assign pinOe_n = st_r.pinOe_n;

endmodule : tco_timer_top

/* verif/tco_pin_model.sv */
// tco_pin_model: pad level of the two compare pins, pulled up when released.
// assumes the top's pinOut and active-low pinOe_n.
`timescale 1ns/10ps
module tco_pin_model
(
  input wire logic [1:0] pinOut,
  input wire logic [1:0] pinOe_n,
  output logic [1:0] padLevel
);
  assign padLevel = (pinOut & ~pinOe_n) | pinOe_n;
endmodule : tco_pin_model

/* verif/tco_timer_assertions.sv */
// tco_timer_assertions: port checks on the timer compare-output top.
// assumes inputs move away from the rising edge of clk.
`timescale 1ns/10ps
module tco_timer_assertions
  import tco_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] clockSelect,
  input wire logic [2:0] waveformGenMode,
  input wire logic [1:0] compareOutputModeA,
  input wire logic [CNT_W-1:0] compareValueA,
  input wire logic countWriteStrobe,
  input wire logic [CNT_W-1:0] countWriteData,
  input wire logic [CH_N-1:0] portData,
  input wire logic [CH_N-1:0] portDirOut,
  input wire logic [CNT_W-1:0] timerCount,
  input wire logic compareMatchFlagA,
  input wire logic overflowFlag,
  input wire logic compareOutputA,
  input wire logic [CH_N-1:0] pinOut,
  input wire logic [CH_N-1:0] pinOe_n
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_oe_follow: assert property (pinOe_n == ~$past(portDirOut))
    else $error("pin enable does not follow direction");
  a_pin_mux: assert property (
    pinOut[0] == ($past(compareOutputModeA) != COM_NONE ? $past(compareOutputA) : $past(portData[0])))
    else $error("pin A source wrong");
  a_write_wins: assert property ($past(countWriteStrobe) |-> timerCount == $past(countWriteData))
    else $error("count write lost");
  // divide-by-one held for two cycles, so a tick is sure at this edge
  a_normal_step: assert property (
    waveformGenMode == WGM_NORMAL && clockSelect == CS_DIV1 && $past(clockSelect, 2) == CS_DIV1
    && !countWriteStrobe |=> timerCount == $past(timerCount) + CNT_ONE)
    else $error("normal count step wrong");
  a_ovf_cause: assert property (
    $rose(overflowFlag) |-> $past(timerCount) == CNT_MAX && timerCount == CNT_BOTTOM)
    else $error("overflow without wrap");
  a_ctc_clear: assert property (
    waveformGenMode == WGM_CTC && clockSelect == CS_DIV1 && $past(clockSelect, 2) == CS_DIV1
    && !countWriteStrobe && !$past(countWriteStrobe) && timerCount == compareValueA
    |=> timerCount == CNT_BOTTOM && compareMatchFlagA)
    else $error("ceiling match did not clear");
  a_flag_cause: assert property (
    $rose(compareMatchFlagA) |-> $past(timerCount) == $past(compareValueA))
    else $error("flag A set without match");
  a_none_hold: assert property (compareOutputModeA == COM_NONE |=> $stable(compareOutputA))
    else $error("output A moved in mode none");
endmodule : tco_timer_assertions

bind tco_timer_top tco_timer_assertions tco_timer_assertions_inst (.clk(clk), .arst_n(arst_n),
  .clockSelect(clockSelect), .waveformGenMode(waveformGenMode), .compareOutputModeA(compareOutputModeA),
  .compareValueA(compareValueA), .countWriteStrobe(countWriteStrobe), .countWriteData(countWriteData),
  .portData(portData), .portDirOut(portDirOut), .timerCount(timerCount),
  .compareMatchFlagA(compareMatchFlagA), .overflowFlag(overflowFlag), .compareOutputA(compareOutputA),
  .pinOut(pinOut), .pinOe_n(pinOe_n));

/* verif/tb_top.sv */
// tb_top: directed scenarios for the timer compare-output block.
// assumes the design package; inputs move 1 ns after the rising edge.
`timescale 1ns/10ps
module tb_top;
  import tco_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, fA = 1'b0, fB = 1'b0;
  logic w1A = 1'b0, w1B = 1'b0, w1O = 1'b0, isA = 1'b0, isB = 1'b0, isO = 1'b0;
  logic [2:0] cs = CS_STOP, wgm = WGM_NORMAL;
  logic [1:0] comA = COM_NONE, comB = COM_NONE, pDir = 2'h0, pData = 2'h0, pin, pinOe_n, pad;
  logic [7:0] ocrA = 8'h00, ocrB = 8'h00, wd = 8'h00, cnt;
  logic flA, flB, ovf, ocA, ocB;
  int error_cnt = 0, cmp_count = 0;
  always #5 clk = ~clk;
  tco_timer_top tco_timer_top_inst (.clk(clk), .arst_n(arst_n), .clockSelect(cs), .waveformGenMode(wgm),
    .compareOutputModeA(comA), .compareOutputModeB(comB), .compareValueA(ocrA), .compareValueB(ocrB),
    .countWriteStrobe(wr), .countWriteData(wd), .forceCompareStrobeA(fA), .forceCompareStrobeB(fB),
    .flagWriteOneA(w1A), .flagWriteOneB(w1B), .flagWriteOneOverflow(w1O), .intServicedA(isA),
    .intServicedB(isB), .intServicedOverflow(isO), .portData(pData), .portDirOut(pDir),
    .timerCount(cnt), .compareMatchFlagA(flA), .compareMatchFlagB(flB), .overflowFlag(ovf),
    .compareOutputA(ocA), .compareOutputB(ocB), .pinOut(pin), .pinOe_n(pinOe_n));
  tco_pin_model tco_pin_model_inst (.pinOut(pin), .pinOe_n(pinOe_n), .padLevel(pad));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic cb(input logic g, input logic e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %0t bit %b not %b", $time, g, e);
    end
  endtask : cb
  task automatic cv(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %0t value %h not %h", $time, g, e);
    end
  endtask : cv
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask : pulse
  task automatic wcnt(input logic [7:0] d);
    wd = d;
    pulse(wr);
  endtask : wcnt
  task automatic waitc(input logic [7:0] v);
    for (int i = 0; i < 300 && cnt !== v; i++)
      step(1);
  endtask : waitc
  task automatic t_force;
    logic [1:0] m [5] = '{COM_SET, COM_CLEAR, COM_TOGGLE, COM_NONE, COM_TOGGLE};
    logic e [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    cv(cnt, CNT_RESET);
    cb(ocA | ocB, OC_RESET);
    cv({6'h00, pinOe_n}, 8'h03);
    wcnt(8'h40);
    // strobes stay high: one force per edge, each with the mode set just before it
    fA = 1'b1;
    fB = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      comA = m[i];
      comB = m[i];
      step(1);
      cb(ocA, e[i]);
      cb(ocB, e[i]);
    end
    fB = 1'b0;
    cb(flA | flB, 1'b0);
    cv(cnt, 8'h40);
    comB = COM_NONE;
    comA = COM_SET;
    step(1);
    fA = 1'b0;
    cb(ocA, 1'b1);
    // port data 0 on A shows the override, port data 1 on B shows the plain port path
    pData = 2'h2;
    pDir = 2'h3;
    step(2);
    cv({6'h00, pad}, 8'h03);
    pDir = 2'h0;
    step(2);
    cv({6'h00, pad}, 8'h03);
    // an odd waveform code is a PWM mode, where a force must leave the output alone
    wgm = 3'h1;
    comA = COM_CLEAR;
    pulse(fA);
    cb(ocA, 1'b1);
    wgm = WGM_NORMAL;
  endtask : t_force
  task automatic t_block;
    ocrA = 8'h05;
    wcnt(8'h05);
    step(2);
    cs = CS_DIV1;
    step(4);
    cb(flA, 1'b0);
    wcnt(8'h04);
    step(2);
    cb(flA, 1'b1);
    pulse(w1A);
    cb(flA, 1'b0);
  endtask : t_block
  task automatic t_normal;
    comA = COM_TOGGLE;
    ocrA = 8'h02;
    wcnt(8'hFC);
    cb(ovf, 1'b0);
    waitc(8'h00);
    cb(ovf, 1'b1);
    step(6);
    cv(cnt, 8'h06);
    cb(flA & ovf, 1'b1);
    pulse(isO);
    pulse(isA);
    cb(ovf | flA, 1'b0);
  endtask : t_normal
  task automatic t_ctc;
    logic o;
    cs = CS_STOP;
    o = ocA;
    wgm = WGM_CTC;
    pulse(isB);
    cb(ocA, o);
    ocrA = 8'h03;
    ocrB = 8'h01;
    wcnt(8'h00);
    cs = CS_DIV1;
    waitc(8'h03);
    o = ocA;
    step(1);
    cv(cnt, 8'h00);
    cb(flA, 1'b1);
    cb(ocA, ~o);
    step(4);
    cv(cnt, 8'h00);
    cb(ocA, o);
    pulse(w1B);
    cb(flB, 1'b0);
    step(1);
    cv(cnt, 8'h02);
    cb(flB, 1'b1);
    ocrA = 8'h01;
    waitc(8'hFF);
    cb(ovf, 1'b0);
    step(1);
    cv(cnt, 8'h00);
    cb(ovf, 1'b1);
    pulse(w1O);
    cb(ovf, 1'b0);
    step(1);
    cv(cnt, 8'h00);
  endtask : t_ctc
  task automatic t_presc;
    logic [2:0] c [5] = '{CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024};
    int n [5] = '{1, 8, 64, 256, 1024};
    logic [7:0] c0;
    wgm = WGM_NORMAL;
    for (int i = 0; i < 5; i++)
    begin
      cs = c[i];
      step(2 * n[i] + 2);
      c0 = cnt;
      step(2 * n[i]);
      cv(cnt, c0 + 8'h02);
    end
  endtask : t_presc
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  initial
  begin
    step(10);
    arst_n = 1'b1;
    step(3);
    t_force();
    t_block();
    t_normal();
    t_ctc();
    t_presc();
    conclude();
  end
  // the run needs about 5700 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end
endmodule : tb_top
